//--- verilog/irxc_pin_irq_ctrl.sv
// irxc_pin_irq_ctrl: transceiver pin direction, receive path and irq merge
// assumes: byte register port with read data one cycle after the strobe,
// gpio pad wires resolved outside from gpio_o and gpio_oe_o
//
// Contract
// [R1] pin a is driven while control bit 7 is one; output after reset
// [R2] pin c is driven while control bit 5 is one; output after reset
// [R3] pin d is driven only while control bit 4 is one; input after reset
// [R4] pin b is driven while control bit 6 is one; output after reset
// [R5] bit 3 one: receive is active high; zero: active low, inverted
// [R6] bit 2 zero routes primary receive pin, one routes auxiliary pin
// [R7] merge field 00 keeps fir and uart irqs on separate pins, default
// [R8] merge field 01 puts combined request on uart pin only
// [R9] merge field 10 puts combined request on fir pin only
// [R10] merge field 11 asserts neither host interrupt pin
// [R11] a driven general pin follows its level bit in the level register
`timescale 1ns/1ns
`default_nettype none
module irxc_pin_irq_ctrl (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire irxc_pkg::irxc_bus_req_s bus_i,
	output logic [irxc_pkg::DATA_W-1:0]  rdata_o,
	input  wire logic [3:0]              gpio_i,
	output logic [3:0]                   gpio_o,
	output logic [3:0]                   gpio_oe_o,
	input  wire logic                    primary_receive_pin_i,
	input  wire logic                    auxiliary_receive_pin_i,
	output logic                         rx_demod_o,
	input  wire logic                    fir_irq_req_i,
	input  wire logic                    uart_irq_req_i,
	output logic                         uart_interrupt_pin_o,
	output logic                         fast_ir_interrupt_pin_o
);
	import irxc_pkg::*;

	irxc_ctrl_s        ctrl_q;
	logic [7:0]        lvl_q;
	logic [7:0]        rdata_q;
	logic [3:0]        drive_vec;
	logic [3:0]        level_vec;
	logic [3:0]        pin_level;
	logic              rx_sel_raw;
	logic              rx_demod_q;
	irxc_status_s      status;

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= irxc_ctrl_s'(CTRL_RST);
		end else if (bus_i.we && bus_i.addr == OFF_PIN_IRQ_CTRL) begin
			ctrl_q <= irxc_ctrl_s'(bus_i.wdata);
		end
	end

	// ----------------------------------------------------------------
	// level register
	// ----------------------------------------------------------------
	// only the four gpio level bits live here; the rest of that
	// register belongs to other logic and reads as zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_q <= LEVEL_RST;
		end else if (bus_i.we && bus_i.addr == OFF_PIN_LEVEL) begin
			lvl_q <= bus_i.wdata & LEVEL_MASK;
		end
	end

	// ----------------------------------------------------------------
	// general purpose pins
	// ----------------------------------------------------------------
	assign drive_vec = {ctrl_q.drive_a, ctrl_q.drive_b,
			ctrl_q.drive_c, ctrl_q.drive_d}; // R1 R2 R3 R4
	assign level_vec = {lvl_q[LVL_A], lvl_q[LVL_B],
			lvl_q[LVL_C], lvl_q[LVL_D]}; // R11

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pad
			irxc_gpio_pad #(
				.RST_DRIVE (DRIVE_RST[gi])
			) u_pad (
				.clk_i       (clk_i),
				.rst_i       (rst_i),
				.drive_i     (drive_vec[gi]),
				.level_i     (level_vec[gi]),
				.pad_i       (gpio_i[gi]),
				.pad_o       (gpio_o[gi]),
				.pad_oe_o    (gpio_oe_o[gi]),
				.pad_level_o (pin_level[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// receive path
	// ----------------------------------------------------------------
	// one flop between pin and demodulators keeps the select mux
	// glitch off the demodulator input
	assign rx_sel_raw = ctrl_q.rx_aux_sel ? auxiliary_receive_pin_i
			: primary_receive_pin_i; // R6

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_demod_q <= 1'b0;
		end else begin
			rx_demod_q <= rx_sel_raw ~^ ctrl_q.rx_active_high; // R5
		end
	end

	assign rx_demod_o = rx_demod_q;

	// ----------------------------------------------------------------
	// interrupt merge
	// ----------------------------------------------------------------
	irxc_irq_merge u_merge (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.mode_i     (ctrl_q.interrupt_merge_field), // R7 R8 R9 R10
		.fir_req_i  (fir_irq_req_i),
		.uart_req_i (uart_irq_req_i),
		.uart_pin_o (uart_interrupt_pin_o),
		.fir_pin_o  (fast_ir_interrupt_pin_o)
	);

	// ----------------------------------------------------------------
	// read back
	// ----------------------------------------------------------------
	always_comb begin
		status          = '0;
		status.pin_in   = pin_level;
		status.rx_demod = rx_demod_q;
		status.uart_pin = uart_interrupt_pin_o;
		status.fir_pin  = fast_ir_interrupt_pin_o;
	end

	// data stand only in the cycle after the read strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= 8'h00;
		end else if (!bus_i.re) begin
			rdata_q <= 8'h00;
		end else if (bus_i.addr == OFF_PIN_IRQ_CTRL) begin
			rdata_q <= ctrl_q;
		end else if (bus_i.addr == OFF_PIN_LEVEL) begin
			rdata_q <= lvl_q;
		end else if (bus_i.addr == OFF_PIN_STATUS) begin
			rdata_q <= status;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign rdata_o = rdata_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_reset_dir: // R1 R2 R3 R4
	assert property (@(posedge clk_i)
		$fell(rst_i) |-> gpio_oe_o == 4'he)
	else $error("pin directions wrong after reset");

	a_drive_a: // R1
	assert property (@(posedge clk_i) disable iff (rst_i)
		bus_i.we && bus_i.addr == OFF_PIN_IRQ_CTRL
		|-> ##2 gpio_oe_o[3] == $past(bus_i.wdata[7], 2))
	else $error("pin a direction does not follow bit 7");

	a_drive_b: // R4
	assert property (@(posedge clk_i) disable iff (rst_i)
		##1 gpio_oe_o[2] == $past(ctrl_q.drive_b))
	else $error("pin b direction does not follow bit 6");

	a_drive_c: // R2
	assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(ctrl_q.drive_c) |=> gpio_oe_o[1])
	else $error("pin c not driven after bit 5 set");

	a_drive_d: // R3
	assert property (@(posedge clk_i) disable iff (rst_i)
		gpio_oe_o[0] |-> $past(ctrl_q.drive_d))
	else $error("pin d driven while bit 4 clear");

	a_rx_polarity: // R5
	assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_q.rx_active_high && $stable(rx_sel_raw)
		|=> rx_demod_o != $past(rx_sel_raw))
	else $error("active low receive not inverted");

	a_rx_primary: // R6
	assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_q.rx_aux_sel |=> rx_demod_o
			== ($past(primary_receive_pin_i) ~^ $past(ctrl_q.rx_active_high)))
	else $error("primary receive pin not routed");

	a_rx_aux: // R6
	assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_q.rx_aux_sel |=> rx_demod_o
			== ($past(auxiliary_receive_pin_i) ~^ $past(ctrl_q.rx_active_high)))
	else $error("auxiliary receive pin not routed");

	a_merge_none: // R7
	assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_q.interrupt_merge_field == MERGE_NONE
		|=> uart_interrupt_pin_o == $past(uart_irq_req_i)
			&& fast_ir_interrupt_pin_o == $past(fir_irq_req_i))
	else $error("separate interrupts not kept apart");

	a_merge_uart: // R8
	assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_q.interrupt_merge_field == MERGE_TO_UART
		|=> !fast_ir_interrupt_pin_o && uart_interrupt_pin_o
			== ($past(uart_irq_req_i) | $past(fir_irq_req_i)))
	else $error("merged request not on uart pin");

	a_merge_fir: // R9
	assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_q.interrupt_merge_field == MERGE_TO_FIR
		|=> !uart_interrupt_pin_o && fast_ir_interrupt_pin_o
			== ($past(uart_irq_req_i) | $past(fir_irq_req_i)))
	else $error("merged request not on fir pin");

	a_merge_off: // R10
	assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_q.interrupt_merge_field == MERGE_OFF
		|=> !uart_interrupt_pin_o && !fast_ir_interrupt_pin_o)
	else $error("host interrupt seen while disabled");

	a_level_follow: // R11
	assert property (@(posedge clk_i) disable iff (rst_i)
		##1 (gpio_o & gpio_oe_o) == ($past(level_vec) & gpio_oe_o))
	else $error("driven pin does not follow its level bit");

	a_read_ctrl:
	assert property (@(posedge clk_i) disable iff (rst_i)
		bus_i.re && bus_i.addr == OFF_PIN_IRQ_CTRL
		|=> rdata_o == $past(ctrl_q))
	else $error("control read back wrong");

endmodule // irxc_pin_irq_ctrl
`default_nettype wire

//--- pkg/irxc_pkg.sv
// irxc_pkg: constants and types of the transceiver pin and irq control block
// assumes: byte-wide register port, one clock, synchronous active-high reset
package irxc_pkg;

	// ----------------------------------------------------------------
	// register port and offsets
	// ----------------------------------------------------------------
	localparam int         ADDR_W           = 4;
	localparam int         DATA_W           = 8;
	localparam logic [3:0] OFF_PIN_LEVEL    = 4'h2;
	localparam logic [3:0] OFF_PIN_IRQ_CTRL = 4'h3;
	localparam logic [3:0] OFF_PIN_STATUS   = 4'h8;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int         LVL_A      = 7;
	localparam int         LVL_B      = 6;
	localparam int         LVL_C      = 5;
	localparam int         LVL_D      = 0;
	localparam logic [7:0] LEVEL_MASK = 8'he1;
	localparam logic [7:0] LEVEL_RST  = 8'h00;
	localparam logic [7:0] CTRL_RST   = 8'he0;
	// gpio index 3..0 is pin a..d, matching control bits 7..4
	localparam logic [3:0] DRIVE_RST  = CTRL_RST[7:4];

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MERGE_NONE    = 2'h0,
		MERGE_TO_UART = 2'h1,
		MERGE_OFF     = 2'h3,
		MERGE_TO_FIR  = 2'h2
	} irxc_merge_e;

	typedef struct packed {
		logic        drive_a;
		logic        drive_b;
		logic        drive_c;
		logic        drive_d;
		logic        rx_active_high;
		logic        rx_aux_sel;
		irxc_merge_e interrupt_merge_field;
	} irxc_ctrl_s;

	typedef struct packed {
		logic [3:0] pin_in;
		logic       rx_demod;
		logic       rsvd;
		logic       uart_pin;
		logic       fir_pin;
	} irxc_status_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              we;
		logic              re;
	} irxc_bus_req_s;

endpackage

//--- verilog/irxc_gpio_pad.sv
// irxc_gpio_pad: one general purpose pin, direction and level registered
// assumes: pad input is synchronous to clk_i; pad wire resolved outside
`timescale 1ns/1ns
`default_nettype none
module irxc_gpio_pad #(
	parameter logic RST_DRIVE = 1'b0
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic drive_i,
	input  wire logic level_i,
	input  wire logic pad_i,
	output logic      pad_o,
	output logic      pad_oe_o,
	output logic      pad_level_o
);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pad_oe_o <= RST_DRIVE;
		end else begin
			pad_oe_o <= drive_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pad_o <= 1'b0;
		end else begin
			pad_o <= level_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pad_level_o <= 1'b0;
		end else begin
			pad_level_o <= pad_i;
		end
	end

endmodule // irxc_gpio_pad
`default_nettype wire

//--- verilog/irxc_irq_merge.sv
// irxc_irq_merge: routes fir and uart requests onto the two host irq pins
// assumes: request inputs are levels synchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
module irxc_irq_merge (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire irxc_pkg::irxc_merge_e mode_i,
	input  wire logic                  fir_req_i,
	input  wire logic                  uart_req_i,
	output logic                       uart_pin_o,
	output logic                       fir_pin_o
);
	import irxc_pkg::*;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			uart_pin_o <= 1'b0;
			fir_pin_o  <= 1'b0;
		end else begin
			case (mode_i)
				MERGE_NONE: begin
					uart_pin_o <= uart_req_i;
					fir_pin_o  <= fir_req_i;
				end
				MERGE_TO_UART: begin
					uart_pin_o <= uart_req_i | fir_req_i;
					fir_pin_o  <= 1'b0;
				end
				MERGE_TO_FIR: begin
					uart_pin_o <= 1'b0;
					fir_pin_o  <= uart_req_i | fir_req_i;
				end
				default: begin
					// masked: pending requests stay inside the block
					uart_pin_o <= 1'b0;
					fir_pin_o  <= 1'b0;
				end
			endcase
		end
	end

endmodule // irxc_irq_merge
`default_nettype wire

//--- sim/irxc_pad_model.sv
// irxc_pad_model: the board side of the four general purpose pads
// assumes: pads have pull-ups; an outside driver only acts while enabled
`timescale 1ns/1ns
`default_nettype none
module irxc_pad_model (
	input  wire logic [3:0] drv_lvl_i,
	input  wire logic [3:0] drv_en_i,
	input  wire logic [3:0] ext_en_i,
	input  wire logic [3:0] ext_lvl_i,
	output logic      [3:0] pad_o
);
	// undriven pads float up, never hold the last driven value
	assign pad_o = (drv_en_i & drv_lvl_i)
		| (~drv_en_i & ext_en_i & ext_lvl_i)
		| (~drv_en_i & ~ext_en_i);
endmodule // irxc_pad_model
`default_nettype wire

//--- sim/test_irxc_pin_irq_ctrl.sv
// test_irxc_pin_irq_ctrl: self-checking bench of the pin and irq control
// assumes: irxc_pkg compiled first; one 10 MHz clock
`timescale 1ns/1ns
`default_nettype none
module test_irxc_pin_irq_ctrl;
	import irxc_pkg::*;
	logic          clk_i = 1'b0;
	logic          rst_i = 1'b1;
	irxc_bus_req_s bus_i = '0;
	logic [7:0]    rdata_o;
	logic [3:0]    gpio_i, gpio_o, gpio_oe_o;
	logic [3:0]    ext_en = 4'h0, ext_lvl = 4'h0;
	logic          prim = 1'b0, aux = 1'b0, rx_demod_o;
	logic          fir_req = 1'b0, uart_req = 1'b0, uart_pin, fir_pin;
	int            miscompares = 0, compares = 0, cycles = 0;

	always #50 clk_i = ~clk_i;

	irxc_pin_irq_ctrl dut (
		.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
		.gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o),
		.primary_receive_pin_i(prim), .auxiliary_receive_pin_i(aux),
		.rx_demod_o(rx_demod_o), .fir_irq_req_i(fir_req), .uart_irq_req_i(uart_req),
		.uart_interrupt_pin_o(uart_pin), .fast_ir_interrupt_pin_o(fir_pin));

	irxc_pad_model pads (
		.drv_lvl_i(gpio_o), .drv_en_i(gpio_oe_o),
		.ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .pad_o(gpio_i));

	// ----------------------------------------------------------------
	// bus and check helpers
	// ----------------------------------------------------------------
	task automatic complete_run();
		if (miscompares == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// a hang shows up as a count well past the few hundred cycles needed
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			complete_run();
		end
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus_i <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clk_i);
		bus_i.we <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i);
		bus_i <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge clk_i);
		bus_i.re <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	// pins are registered levels; two edges cover the register stage
	task automatic settle();
		@(posedge clk_i);
		@(posedge clk_i);
		#1;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic reset_values();
		logic [7:0] d;
		check({4'h0, gpio_oe_o}, 8'h0e, "oe after reset");
		rd(OFF_PIN_IRQ_CTRL, d);
		check(d, 8'he0, "ctrl reset");
	endtask

	task automatic direction_and_level();
		logic [7:0] d;
		for (int i = 0; i < 5; i++) begin
			wr(OFF_PIN_IRQ_CTRL, 8'h10 << i);
			settle();
			check({4'h0, gpio_oe_o}, (8'h10 << i) >> 4, "direction");
		end
		wr(OFF_PIN_IRQ_CTRL, 8'hf0);
		wr(OFF_PIN_LEVEL, 8'hbf);
		settle();
		check({4'h0, gpio_o}, 8'h0b, "pad level");
		rd(OFF_PIN_LEVEL, d);
		check(d, 8'ha1, "level reg");
		rd(4'hf, d);
		check(d, 8'h00, "unmapped read");
		wr(4'hf, 8'hff);
		rd(OFF_PIN_LEVEL, d);
		check(d, 8'ha1, "unmapped write");
		// released pads: outside drives a,c low, b,d left to pull-up
		wr(OFF_PIN_IRQ_CTRL, 8'h00);
		ext_en <= 4'ha;
		ext_lvl <= 4'h0;
		settle();
		rd(OFF_PIN_STATUS, d);
		check(d & 8'hf0, 8'h50, "pad input");
	endtask

	task automatic receive_path();
		logic [3:0] k;
		logic       e;
		for (int i = 0; i < 16; i++) begin
			// stimulus moves on a rising edge, not at the settle skew
			@(posedge clk_i);
			k = i[3:0];
			prim <= k[1];
			aux <= k[0];
			wr(OFF_PIN_IRQ_CTRL, {4'h0, k[3:2], 2'h0});
			settle();
			e = (k[2] ? k[0] : k[1]) ~^ k[3];
			check({7'h0, rx_demod_o}, {7'h0, e}, "rx demod");
		end
	endtask

	task automatic irq_merge();
		logic [1:0] m, r, e;
		logic [7:0] d;
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			wr(OFF_PIN_IRQ_CTRL, {6'h0, m});
			for (int j = 0; j < 4; j++) begin
				@(posedge clk_i);
				r = j[1:0];
				fir_req <= r[1];
				uart_req <= r[0];
				settle();
				case (m)
					2'h0: e = {r[0], r[1]};
					2'h1: e = {|r, 1'b0};
					2'h2: e = {1'b0, |r};
					default: e = 2'h0;
				endcase
				check({6'h0, uart_pin, fir_pin}, {6'h0, e}, "irq pins");
				rd(OFF_PIN_STATUS, d);
				check({6'h0, d[1:0]}, {6'h0, e}, "irq status");
			end
		end
	endtask

	// reset in mid-run must undo register writes, not only power-up state
	task automatic reset_mid_run();
		logic [7:0] d;
		wr(OFF_PIN_IRQ_CTRL, 8'h1f);
		wr(OFF_PIN_LEVEL, 8'hff);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		settle();
		check({gpio_oe_o, gpio_o}, 8'he0, "pins after reset");
		rd(OFF_PIN_IRQ_CTRL, d);
		check(d, 8'he0, "ctrl after reset");
		rd(OFF_PIN_LEVEL, d);
		check(d, 8'h00, "level after reset");
	endtask

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		settle();
		reset_values();
		direction_and_level();
		receive_path();
		irq_merge();
		reset_mid_run();
		complete_run();
	end
endmodule // test_irxc_pin_irq_ctrl
`default_nettype wire
